// ===== core/alu_pkg.sv
// Constants, operation codes and flag layout of the core arithmetic unit.
// Assumes the instruction decoder supplies operands and takes results back.
// Function
// [RULE1] Word/byte add, optionally adding incoming carry
// [RULE2] Word/byte subtract, optionally subtracting incoming borrow
// [RULE3] Signed or unsigned sixteen by sixteen multiply
// [RULE4] Signed/unsigned divide low word by register
// [RULE5] Signed/unsigned divide doubleword by register
// [RULE6] Ones complement or negate, word or byte
// [RULE7] Bitwise AND, OR, XOR on words/bytes
// [RULE8] Clear or set one addressed bit
// [RULE9] Copy direct bit, plain or inverted
// [RULE10] AND/OR/XOR source bit into destination bit
// [RULE11] Bit compare updates flags only
// [RULE12] Masked high/low byte load from immediate
// [RULE13] Compare word/byte, flags only, no writeback
// [RULE14] Compare then decrement register by one/two
// [RULE15] Compare then increment register by one/two
// [RULE16] Count normalising shifts into destination register
// [RULE17] Shift word register toward msb or lsb
// [RULE18] Results update carry, zero, negative, overflow flags
// [RULE19] Byte forms keep the register's high byte
package alu_pkg;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int LONG_W = 32;
    localparam int DIV_STEPS = 32;
    localparam int FLAG_W = 4;
    // Flag positions in the flag word
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_V = 2;
    localparam int FLAG_N = 3;
    localparam logic [3:0] MSB_BYTE = 4'h7;
    localparam logic [3:0] MSB_WORD = 4'hF;
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_TWO = 16'h0002;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [31:0] LONG_ZERO = 32'h00000000;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    typedef enum logic [5:0] {
        OP_SUM = 6'h00, OP_SUM_CARRY = 6'h01, OP_DIFF = 6'h02, OP_DIFF_BORROW = 6'h03,
        OP_PRODUCT_S = 6'h04, OP_PRODUCT_U = 6'h05, OP_QUOT_S = 6'h06, OP_QUOT_U = 6'h07,
        OP_LQUOT_S = 6'h08, OP_LQUOT_U = 6'h09, OP_ONES_COMP = 6'h0A, OP_SIGN_FLIP = 6'h0B,
        OP_AND = 6'h0C, OP_OR = 6'h0D, OP_XOR = 6'h0E, OP_BIT_CLEAR = 6'h0F,
        OP_BIT_SET = 6'h10, OP_BIT_COPY = 6'h11, OP_BIT_COPY_INV = 6'h12,
        OP_BIT_CONJ = 6'h13, OP_BIT_DISJ = 6'h14, OP_BIT_EXOR = 6'h15,
        OP_BIT_COMPARE = 6'h16, OP_FIELD_HIGH = 6'h17, OP_FIELD_LOW = 6'h18,
        OP_COMPARE = 6'h19, OP_COMPARE_DEC1 = 6'h1A, OP_COMPARE_DEC2 = 6'h1B,
        OP_COMPARE_INC1 = 6'h1C, OP_COMPARE_INC2 = 6'h1D, OP_NORM_COUNT = 6'h1E,
        OP_SHIFT_MSB = 6'h1F, OP_SHIFT_LSB = 6'h20
    } op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DIVIDE = 2'b10
    } state_e;
endpackage

// ===== core/div_if.sv
// Handshake between the arithmetic unit and its iterative divider.
// Assumes both ends share one clock; start and done are one-cycle pulses.
`timescale 1ns/1ps
interface div_if;
    logic start;
    logic [31:0] dividend;
    logic [15:0] divisor;
    logic done;
    logic [31:0] quotient;
    logic [15:0] remainder;
    modport ctrl (output start, dividend, divisor, input done, quotient, remainder);
    modport unit (input start, dividend, divisor, output done, quotient, remainder);
endinterface

// ===== core/div_unit.sv
// Restoring divider, one quotient bit per clock, unsigned magnitudes only.
// Assumes divisor is non-zero; sign handling sits in the caller.
`timescale 1ns/1ps
module div_unit
    import alu_pkg::*;
#(
    parameter int STEPS = DIV_STEPS
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Divider handshake
    div_if.unit dv
);
    // Only the full doubleword width is wired through the datapath
    if (STEPS != LONG_W) begin : g_chk
        $error("div_unit: STEPS must equal the dividend width");
    end

    logic busy, next_busy;
    logic done, next_done;
    logic [5:0] count, next_count;
    logic [31:0] quot, next_quot;
    logic [15:0] rem, next_rem;
    logic [15:0] dvs, next_dvs;

    // One trial subtraction per step
    always_comb begin
        logic [16:0] trial;
        trial = {rem, quot[31]};
        next_busy = busy;
        next_done = 1'b0;
        next_count = count;
        next_quot = quot;
        next_rem = rem;
        next_dvs = dvs;
        if (busy) begin
            if (trial >= {1'b0, dvs}) begin
                next_rem = 16'(trial - {1'b0, dvs});
                next_quot = {quot[30:0], 1'b1};
            end else begin
                next_rem = trial[15:0];
                next_quot = {quot[30:0], 1'b0};
            end
            next_count = 6'(count + 6'h01);
            if (count == 6'(STEPS - 1)) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end else if (dv.start) begin
            next_busy = 1'b1;
            next_count = 6'h00;
            next_quot = dv.dividend;
            next_rem = WORD_ZERO;
            next_dvs = dv.divisor;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            busy <= 1'b0;
            done <= 1'b0;
            count <= 6'h00;
            quot <= LONG_ZERO;
            rem <= WORD_ZERO;
            dvs <= WORD_ZERO;
        end else begin
            busy <= next_busy;
            done <= next_done;
            count <= next_count;
            quot <= next_quot;
            rem <= next_rem;
            dvs <= next_dvs;
        end
    end

    assign dv.done = done;
    assign dv.quotient = quot;
    assign dv.remainder = rem;
endmodule

// ===== core/cpu_arith_logic_bit_unit.sv
// Arithmetic, logic, bit, compare and shift datapath of the core.
// Assumes the decoder presents one operation with start_in and waits for done_out.
`timescale 1ns/1ps
module cpu_arith_logic_bit_unit
    import alu_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Operation request
    input wire logic start_in,
    input wire op_e op_in,
    input wire logic byte_in,
    input wire logic carry_in,
    // Operands
    input wire logic [15:0] dest_in,
    input wire logic [15:0] src_in,
    input wire logic [3:0] dest_bit_in,
    input wire logic [3:0] src_bit_in,
    input wire logic [7:0] mask_in,
    input wire logic [31:0] pair_in,
    // Results
    output logic done_out,
    output logic busy_out,
    output logic [15:0] result_out,
    output logic result_write_out,
    output logic [15:0] pointer_out,
    output logic pointer_write_out,
    output logic [31:0] pair_out,
    output logic pair_write_out,
    output logic [3:0] flags_out
);
    div_if dv ();

    state_e state, next_state;
    logic next_done, next_busy;
    logic [15:0] next_result, next_pointer;
    logic next_result_wr, next_pointer_wr, next_pair_wr;
    logic [31:0] next_pair;
    logic [3:0] next_flags;
    logic div_start, next_div_start;
    logic [31:0] div_dvd, next_div_dvd;
    logic [15:0] div_dvs, next_div_dvs;
    logic neg_q, next_neg_q, neg_r, next_neg_r, div_signed, next_div_signed;
    logic accept;

    // Requests arriving during a divide are ignored
    assign accept = start_in && (state == ST_IDLE);

    // Divider runs alone, so the unit just hands over magnitudes
    div_unit #(.STEPS(DIV_STEPS)) u_div (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .dv(dv.unit)
    );
    assign dv.start = div_start;
    assign dv.dividend = div_dvd;
    assign dv.divisor = div_dvs;

    // Whole datapath: one pass per request, divide finishes later
    always_comb begin
        logic [15:0] opa, opb, r;
        logic [16:0] sum, diff, negv, cmpv;
        logic [31:0] prod, wide, dvd, qs;
        logic [15:0] dvs, rs;
        logic [3:0] msb;
        logic cin, c, v, sb, db, nb, sgn, flags_fixed;
        msb = byte_in ? MSB_BYTE : MSB_WORD;
        opa = byte_in ? {8'h00, dest_in[7:0]} : dest_in;
        opb = byte_in ? {8'h00, src_in[7:0]} : src_in;
        cin = carry_in && ((op_in == OP_SUM_CARRY) || (op_in == OP_DIFF_BORROW));
        sum = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
        diff = {1'b0, opa} - {1'b0, opb} - {16'h0000, cin};
        negv = 17'h00000 - {1'b0, opa};
        cmpv = {1'b0, dest_in} - {1'b0, src_in};
        sgn = (op_in == OP_PRODUCT_S) || (op_in == OP_QUOT_S) || (op_in == OP_LQUOT_S);
        // Operands widened first so no product bit is lost
        prod = sgn ? {{16{dest_in[15]}}, dest_in} * {{16{src_in[15]}}, src_in}
            : {16'h0000, dest_in} * {16'h0000, src_in};
        dvd = ((op_in == OP_QUOT_S) || (op_in == OP_QUOT_U))
            ? (sgn ? {{16{pair_in[15]}}, pair_in[15:0]} : {16'h0000, pair_in[15:0]}) : pair_in;
        dvs = src_in;
        sb = src_in[src_bit_in];
        db = dest_in[dest_bit_in];
        nb = db;
        r = dest_in;
        c = 1'b0;
        v = 1'b0;
        flags_fixed = 1'b0;
        wide = LONG_ZERO;
        qs = LONG_ZERO;
        rs = WORD_ZERO;
        next_state = state;
        next_done = 1'b0;
        next_result = result_out;
        next_result_wr = 1'b0;
        next_pointer = pointer_out;
        next_pointer_wr = 1'b0;
        next_pair = pair_out;
        next_pair_wr = 1'b0;
        next_flags = flags_out;
        next_div_start = 1'b0;
        next_div_dvd = div_dvd;
        next_div_dvs = div_dvs;
        next_neg_q = neg_q;
        next_neg_r = neg_r;
        next_div_signed = div_signed;
        if (accept) begin
            next_done = 1'b1;
            next_result_wr = 1'b1;
            unique case (op_in)
                OP_SUM, OP_SUM_CARRY: begin // [RULE1]
                    r = sum[15:0];
                    c = byte_in ? sum[BYTE_W] : sum[WORD_W];
                    v = (opa[msb] == opb[msb]) && (r[msb] != opa[msb]);
                end
                OP_DIFF, OP_DIFF_BORROW, OP_COMPARE: begin // [RULE2] [RULE13]
                    r = diff[15:0];
                    c = byte_in ? diff[BYTE_W] : diff[WORD_W];
                    v = (opa[msb] != opb[msb]) && (r[msb] != opa[msb]);
                    next_result_wr = (op_in != OP_COMPARE); // [RULE13]
                end
                OP_COMPARE_DEC1, OP_COMPARE_DEC2, OP_COMPARE_INC1, OP_COMPARE_INC2: begin
                    // Flags from a word compare, then the pointer moves
                    r = cmpv[15:0];
                    c = cmpv[WORD_W];
                    v = (dest_in[15] != src_in[15]) && (r[15] != dest_in[15]);
                    next_result_wr = 1'b0;
                    next_pointer_wr = 1'b1;
                    unique case (op_in)
                        OP_COMPARE_DEC1: next_pointer = 16'(dest_in - STEP_ONE); // [RULE14]
                        OP_COMPARE_DEC2: next_pointer = 16'(dest_in - STEP_TWO); // [RULE14]
                        OP_COMPARE_INC1: next_pointer = 16'(dest_in + STEP_ONE); // [RULE15]
                        default: next_pointer = 16'(dest_in + STEP_TWO); // [RULE15]
                    endcase
                end
                OP_PRODUCT_S, OP_PRODUCT_U: begin // [RULE3]
                    next_result_wr = 1'b0;
                    next_pair = prod;
                    next_pair_wr = 1'b1;
                    flags_fixed = 1'b1;
                    next_flags = FLAGS_RESET;
                    next_flags[FLAG_Z] = (prod == LONG_ZERO);
                    next_flags[FLAG_N] = prod[31];
                    // Overflow means the product needs the high word
                    next_flags[FLAG_V] = sgn ? (prod[31:16] != {16{prod[15]}})
                        : (prod[31:16] != WORD_ZERO);
                end
                OP_QUOT_S, OP_QUOT_U, OP_LQUOT_S, OP_LQUOT_U: begin // [RULE4] [RULE5]
                    next_result_wr = 1'b0;
                    if (src_in == WORD_ZERO) begin
                        // Divide by zero: flag it, leave the pair alone
                        flags_fixed = 1'b1;
                        next_flags = FLAGS_RESET;
                        next_flags[FLAG_V] = 1'b1;
                    end else begin
                        next_done = 1'b0;
                        next_state = ST_DIVIDE;
                        next_div_start = 1'b1;
                        next_div_signed = sgn;
                        next_neg_q = sgn && (dvd[31] ^ dvs[15]);
                        next_neg_r = sgn && dvd[31];
                        next_div_dvd = (sgn && dvd[31]) ? 32'(LONG_ZERO - dvd) : dvd;
                        next_div_dvs = (sgn && dvs[15]) ? 16'(WORD_ZERO - dvs) : dvs;
                        flags_fixed = 1'b1;
                    end
                end
                OP_ONES_COMP: r = ~opa; // [RULE6]
                OP_SIGN_FLIP: begin // [RULE6]
                    r = negv[15:0];
                    c = byte_in ? negv[BYTE_W] : negv[WORD_W];
                    v = opa[msb] && r[msb];
                end
                OP_AND: r = opa & opb; // [RULE7]
                OP_OR: r = opa | opb; // [RULE7]
                OP_XOR: r = opa ^ opb; // [RULE7]
                OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_COPY, OP_BIT_COPY_INV, OP_BIT_CONJ,
                OP_BIT_DISJ, OP_BIT_EXOR, OP_BIT_COMPARE: begin
                    unique case (op_in)
                        OP_BIT_CLEAR: nb = 1'b0; // [RULE8]
                        OP_BIT_SET: nb = 1'b1; // [RULE8]
                        OP_BIT_COPY: nb = sb; // [RULE9]
                        OP_BIT_COPY_INV: nb = ~sb; // [RULE9]
                        OP_BIT_CONJ: nb = db & sb; // [RULE10]
                        OP_BIT_DISJ: nb = db | sb; // [RULE10]
                        OP_BIT_EXOR: nb = db ^ sb; // [RULE10]
                        default: nb = db; // [RULE11]
                    endcase
                    r = (dest_in & ~(STEP_ONE << dest_bit_in)) | (16'(nb) << dest_bit_in);
                    next_result_wr = (op_in != OP_BIT_COMPARE); // [RULE11]
                    // Flags describe the two bits before the write
                    flags_fixed = 1'b1;
                    next_flags[FLAG_C] = db & sb;
                    next_flags[FLAG_V] = db | sb;
                    next_flags[FLAG_Z] = ~db;
                    next_flags[FLAG_N] = db ^ sb;
                end
                OP_FIELD_HIGH: r = (dest_in & ~{mask_in, 8'h00}) // [RULE12]
                    | {src_in[7:0] & mask_in, 8'h00};
                OP_FIELD_LOW: r = (dest_in & ~{8'h00, mask_in}) // [RULE12]
                    | {8'h00, src_in[7:0] & mask_in};
                OP_NORM_COUNT: begin // [RULE16]
                    r = WORD_ZERO;
                    for (int i = 0; i < WORD_W; i++) begin
                        if (dest_in[i]) begin
                            r = 16'(WORD_W - 1 - i);
                        end
                    end
                end
                OP_SHIFT_MSB: begin // [RULE17]
                    wide = {16'h0000, dest_in} << src_in[3:0];
                    r = wide[15:0];
                    c = wide[WORD_W];
                end
                default: begin // [RULE17]
                    wide = {dest_in, 16'h0000} >> src_in[3:0];
                    r = wide[31:16];
                    c = wide[15];
                end
            endcase
            // Byte forms only ever touch the low byte
            if (byte_in && (op_in inside {OP_SUM, OP_SUM_CARRY, OP_DIFF, OP_DIFF_BORROW,
                OP_COMPARE, OP_ONES_COMP, OP_SIGN_FLIP, OP_AND, OP_OR, OP_XOR})) begin
                r = {dest_in[15:8], r[7:0]}; // [RULE19]
            end
            if (!flags_fixed) begin // [RULE18]
                next_flags[FLAG_C] = c;
                next_flags[FLAG_V] = v;
                next_flags[FLAG_Z] = byte_in ? (r[7:0] == 8'h00) : (r == WORD_ZERO);
                next_flags[FLAG_N] = r[msb];
            end
            next_result = r;
        end else if ((state == ST_DIVIDE) && dv.done) begin
            // Signs restored here; remainder takes the dividend's sign
            qs = neg_q ? 32'(LONG_ZERO - dv.quotient) : dv.quotient;
            rs = neg_r ? 16'(WORD_ZERO - dv.remainder) : dv.remainder;
            next_pair = {rs, qs[15:0]}; // [RULE4] [RULE5]
            next_pair_wr = 1'b1;
            next_done = 1'b1;
            next_state = ST_IDLE;
            next_flags = FLAGS_RESET;
            next_flags[FLAG_V] = div_signed ? (qs[31:16] != {16{qs[15]}})
                : (qs[31:16] != WORD_ZERO);
            next_flags[FLAG_Z] = (qs[15:0] == WORD_ZERO);
            next_flags[FLAG_N] = qs[15];
        end
        next_busy = (next_state == ST_DIVIDE);
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
            done_out <= 1'b0;
            busy_out <= 1'b0;
            result_out <= WORD_ZERO;
            result_write_out <= 1'b0;
            pointer_out <= WORD_ZERO;
            pointer_write_out <= 1'b0;
            pair_out <= LONG_ZERO;
            pair_write_out <= 1'b0;
            flags_out <= FLAGS_RESET;
            div_start <= 1'b0;
            div_dvd <= LONG_ZERO;
            div_dvs <= WORD_ZERO;
            neg_q <= 1'b0;
            neg_r <= 1'b0;
            div_signed <= 1'b0;
        end else begin
            state <= next_state;
            done_out <= next_done;
            busy_out <= next_busy;
            result_out <= next_result;
            result_write_out <= next_result_wr;
            pointer_out <= next_pointer;
            pointer_write_out <= next_pointer_wr;
            pair_out <= next_pair;
            pair_write_out <= next_pair_wr;
            flags_out <= next_flags;
            div_start <= next_div_start;
            div_dvd <= next_div_dvd;
            div_dvs <= next_div_dvs;
            neg_q <= next_neg_q;
            neg_r <= next_neg_r;
            div_signed <= next_div_signed;
        end
    end

    // Checks on what the datapath drives
    sum_word_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE1]
        accept && op_in == OP_SUM_CARRY && !byte_in |=>
        result_out == 16'($past(dest_in) + $past(src_in) + 16'($past(carry_in))))
        else $error("word add with carry wrong");
    diff_byte_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE2]
        accept && op_in == OP_DIFF && byte_in |=>
        result_out[7:0] == 8'($past(dest_in[7:0]) - $past(src_in[7:0])))
        else $error("byte subtract wrong");
    product_u_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE3]
        accept && op_in == OP_PRODUCT_U |=> pair_write_out
        && pair_out == 32'($past(dest_in)) * 32'($past(src_in)))
        else $error("unsigned product wrong");
    divide_time_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE4]
        accept && op_in inside {OP_QUOT_U, OP_LQUOT_U} && src_in != WORD_ZERO
        |=> busy_out && !done_out ##34 done_out && pair_write_out && !busy_out)
        else $error("divide did not finish on time");
    ones_comp_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE6]
        accept && op_in == OP_ONES_COMP && !byte_in |=> result_out == ~$past(dest_in))
        else $error("complement wrong");
    bit_set_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE8]
        accept && op_in == OP_BIT_SET |=> result_write_out
        && result_out == ($past(dest_in) | (STEP_ONE << $past(dest_bit_in))))
        else $error("bit set wrong");
    bit_compare_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE11]
        accept && op_in == OP_BIT_COMPARE |=> done_out && !result_write_out)
        else $error("bit compare wrote back");
    compare_only_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE13]
        accept && op_in == OP_COMPARE && !byte_in |=> !result_write_out && !pair_write_out
        && flags_out[FLAG_Z] == ($past(dest_in) == $past(src_in)))
        else $error("compare wrote back or bad zero");
    pointer_dec_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE14]
        accept && op_in == OP_COMPARE_DEC2 |=> pointer_write_out
        && pointer_out == 16'($past(dest_in) - STEP_TWO))
        else $error("pointer decrement wrong");
    byte_keep_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE19]
        accept && byte_in && op_in inside {OP_SUM, OP_AND, OP_SIGN_FLIP, OP_DIFF}
        |=> result_out[15:8] == $past(dest_in[15:8]))
        else $error("byte form touched high byte");
endmodule

// ===== test/alu_partner.sv
// Register file model standing beyond the unit: keeps the last written values.
// Assumes write strobes are one-cycle pulses sampled on the rising clock edge.
`timescale 1ns/1ps
module alu_partner (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Write strobes from the unit
    input wire logic [15:0] result_in,
    input wire logic result_write_in,
    input wire logic [15:0] pointer_in,
    input wire logic pointer_write_in,
    // Stored registers
    output logic [15:0] kept_out,
    output logic [15:0] ptr_out
);
    // Capture only on strobes, so a stray or missing strobe shows up as stale data
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            kept_out <= 16'h0000;
            ptr_out <= 16'h0000;
        end else begin
            if (result_write_in)
                kept_out <= result_in;
            if (pointer_write_in)
                ptr_out <= pointer_in;
        end
    end
endmodule

// ===== test/cpu_arith_logic_bit_unit_test.sv
// Self-checking bench for the core arithmetic unit, one task per scenario.
// Assumes every answer comes within 40 cycles; inputs change on falling edges.
`timescale 1ns/1ps
module cpu_arith_logic_bit_unit_test;
    import alu_pkg::*;
    logic clk_sys_in, start_in = 1'b0, done_out, busy_out, result_write_out;
    logic rst_in = 1'b1, byte_in = 1'b0, carry_in = 1'b0, pointer_write_out, pair_write_out;
    op_e op_in = OP_SUM;
    logic [15:0] dest_in = 16'h0000, src_in = 16'h0000, result_out, pointer_out, kept, ptr;
    logic [3:0] dest_bit_in = 4'h0, src_bit_in = 4'h0, flags_out;
    logic [7:0] mask_in = 8'h00;
    logic [31:0] pair_in = 32'h00000000, pair_out;
    int failures = 0;
    int checks = 0;
    // Unit under test and register file model
    cpu_arith_logic_bit_unit dut (.clk_sys_in, .rst_in, .start_in, .op_in, .byte_in,
        .carry_in, .dest_in, .src_in, .dest_bit_in, .src_bit_in, .mask_in, .pair_in, .done_out,
        .busy_out, .result_out, .result_write_out, .pointer_out, .pointer_write_out, .pair_out,
        .pair_write_out, .flags_out);
    alu_partner regs (.clk_sys_in, .rst_in, .result_in(result_out),
        .result_write_in(result_write_out), .pointer_in(pointer_out),
        .pointer_write_in(pointer_write_out), .kept_out(kept), .ptr_out(ptr));
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // One request, then wait for the answer under a bound
    task automatic run(input op_e o, input logic b, input logic [15:0] d, input logic [15:0] s);
        int n;
        logic slow;
        @(negedge clk_sys_in);
        op_in = o;
        byte_in = b;
        dest_in = d;
        src_in = s;
        start_in = 1'b1;
        @(negedge clk_sys_in);
        start_in = 1'b0;
        slow = o inside {OP_QUOT_S, OP_QUOT_U, OP_LQUOT_S, OP_LQUOT_U} && s != 16'h0000;
        chk("busy", busy_out, slow);
        n = 0;
        while (done_out !== 1'b1 && n < 40) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk("answer in time", n < 40, 1'b1);
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_arith();
        run(OP_SUM, 1'b0, 16'hFFFF, 16'h0001);
        chk("sum", result_out, 32'h0);
        chk("sum flags", flags_out, 32'h3);
        carry_in = 1'b1;
        run(OP_SUM_CARRY, 1'b1, 16'hAB7F, 16'h0000);
        chk("sum carry byte", result_out, 32'hAB80);
        chk("sum carry flags", flags_out, 32'hC);
        run(OP_DIFF_BORROW, 1'b0, 16'h0005, 16'h0003);
        chk("diff borrow", result_out, 32'h1);
        run(OP_SIGN_FLIP, 1'b0, 16'h0001, 16'h0001);
        chk("negate", result_out, 32'hFFFF);
        run(OP_ONES_COMP, 1'b1, 16'h12F0, 16'h12F0);
        chk("complement byte", result_out, 32'h120F);
        run(OP_DIFF, 1'b1, 16'h3412, 16'h5513);
        chk("diff byte", {flags_out, result_out}, 32'h934FF);
    endtask
    task automatic t_muldiv();
        pair_in = 32'h00000064;
        run(OP_PRODUCT_U, 1'b0, 16'hFFFF, 16'h0002);
        chk("product u", pair_out, 32'h0001FFFE);
        run(OP_PRODUCT_S, 1'b0, 16'hFFFF, 16'h0002);
        chk("product s", pair_out, 32'hFFFFFFFE);
        run(OP_QUOT_U, 1'b0, 16'h0007, 16'h0007);
        chk("quotient", pair_out, 32'h0002000E);
        run(OP_QUOT_U, 1'b0, 16'h0000, 16'h0000);
        chk("div zero write", pair_write_out, 32'h0);
        pair_in = 32'hFFFFFFF9;
        run(OP_QUOT_S, 1'b0, 16'h0002, 16'h0002);
        chk("quotient s", pair_out, 32'hFFFFFFFD);
        run(OP_LQUOT_S, 1'b0, 16'h0002, 16'h0002);
        chk("long quotient s", pair_out, 32'hFFFFFFFD);
        pair_in = 32'h00010000;
        run(OP_LQUOT_U, 1'b0, 16'h0002, 16'h0002);
        chk("long quotient u", pair_out, 32'h00008000);
    endtask
    task automatic t_logic_bits();
        op_e lo[3] = '{OP_AND, OP_OR, OP_XOR};
        logic [15:0] lw[3] = '{16'hF000, 16'hFFF0, 16'h0FF0};
        op_e bo[5] = '{OP_BIT_COPY, OP_BIT_COPY_INV, OP_BIT_CONJ, OP_BIT_DISJ, OP_BIT_EXOR};
        logic [15:0] bw[5] = '{16'h0008, 16'h0000, 16'h0000, 16'h0008, 16'h0008};
        for (int i = 0; i < 3; i++) begin
            run(lo[i], 1'b0, 16'hF0F0, 16'hFF00);
            chk("logic", result_out, lw[i]);
        end
        dest_bit_in = 4'h3;
        run(OP_BIT_CLEAR, 1'b0, 16'hFFFF, 16'h0001);
        chk("bit clear", result_out, 32'hFFF7);
        run(OP_BIT_SET, 1'b0, 16'h0000, 16'h0001);
        chk("bit set", result_out, 32'h0008);
        for (int i = 0; i < 5; i++) begin
            run(bo[i], 1'b0, 16'h0000, 16'h0001);
            chk("bit combine", result_out, bw[i]);
        end
        run(OP_BIT_COMPARE, 1'b0, 16'h0000, 16'h0001);
        chk("bit compare write", result_write_out, 32'h0);
        chk("bit compare flags", flags_out, 32'hE);
        mask_in = 8'h0F;
        run(OP_FIELD_LOW, 1'b0, 16'h1234, 16'h00AB);
        chk("field low", result_out, 32'h123B);
        mask_in = 8'hF0;
        run(OP_FIELD_HIGH, 1'b0, 16'h1234, 16'h00AB);
        chk("field high", result_out, 32'hA234);
    endtask
    task automatic t_compare_shift();
        op_e co[4] = '{OP_COMPARE_DEC1, OP_COMPARE_DEC2, OP_COMPARE_INC1, OP_COMPARE_INC2};
        logic [15:0] cw[4] = '{16'h000F, 16'h000E, 16'h0011, 16'h0012};
        run(OP_AND, 1'b0, 16'h5A5A, 16'hFFFF);
        run(OP_COMPARE, 1'b0, 16'h0005, 16'h0005);
        chk("compare flags", flags_out, 32'h2);
        chk("compare write", result_write_out, 32'h0);
        for (int i = 0; i < 4; i++) begin
            run(co[i], 1'b0, 16'h0010, 16'h0001);
            @(negedge clk_sys_in);
            chk("pointer update", ptr, cw[i]);
        end
        chk("register kept", kept, 32'h5A5A);
        run(OP_NORM_COUNT, 1'b0, 16'h0010, 16'h0010);
        chk("normalize", result_out, 32'h000B);
        run(OP_SHIFT_MSB, 1'b0, 16'h8001, 16'h0001);
        chk("shift msb", {flags_out, result_out}, 32'h10002);
        run(OP_SHIFT_LSB, 1'b0, 16'h8001, 16'h0001);
        chk("shift lsb", {flags_out, result_out}, 32'h14000);
    endtask
    // Free-running 25 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    // Main sequence
    initial begin
        repeat (8) @(negedge clk_sys_in);
        rst_in = 1'b0;
        chk("reset flags", flags_out, 32'h0);
        t_arith();
        t_muldiv();
        t_logic_bits();
        t_compare_shift();
        give_verdict();
    end
    // Watchdog: the whole run needs well under 1000 cycles
    initial begin
        #80000;
        failures++;
        give_verdict();
    end
endmodule
